// *** core/iopi_cfg.svh ***
// Notes on behaviour
// - The sixteen input channels are delivered as a two-byte input image.
// - The pin-4 channel of input connector k appears at image bit 2k.
// - The pin-2 channel of input connector k appears at image bit 2k+1.
// - Each input connector carries channel n on pin 4 and n+1 on pin 2.
// - An input indicator is dark when inactive and green when active.
// - An indicator is red on short; inputs report shorts per connector.
// - The output side takes one byte from the interface unit for 8 outputs.
// - Each output connector carries channel n on pin 4 and n+1 on pin 2.
// - An output indicator is dark, green when driven, red when shorted.
`ifndef IOPI_CFG_SVH
`define IOPI_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IOPI_OFF_IN_IMAGE   12'h000
`define IOPI_OFF_OUT_IMAGE  12'h004
`define IOPI_OFF_SHORTS     12'h008
`define IOPI_OFF_IRQ_STAT   12'h00C
`define IOPI_OFF_IRQ_CLR    12'h010
`define IOPI_OFF_IRQ_EN     12'h014
`define IOPI_OFF_CTRL       12'h018

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define IOPI_CTRL_W         2
`define IOPI_CTRL_OUT_EN    0
`define IOPI_CTRL_CUTOFF    1
`define IOPI_CTRL_RST       2'h1
`define IOPI_IRQ_W          4
`define IOPI_EV_IN_CHG      0
`define IOPI_EV_IN_SHORT    1
`define IOPI_EV_OUT_SHORT   2
`define IOPI_EV_OUT_BYTE    3
`define IOPI_IRQ_RST        4'h0
`define IOPI_SHORTS_OUT_LSB 16

`endif

// *** core/iopi_pkg.sv ***
`default_nettype none
package iopi_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } iopi_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } iopi_apb_rsp_t;

endpackage
`default_nettype wire

// *** core/iopi_led.sv ***
`default_nettype none
// ----------------------------------------
// three-state channel indicator
// ----------------------------------------
module iopi_led #(
    parameter int N = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] active,
    input  wire logic [N-1:0] short_det,
    output logic      [N-1:0] green_q,
    output logic      [N-1:0] red_q
);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            green_q <= '0;
            red_q   <= '0;
        end
        else
        begin
            red_q   <= short_det;
            green_q <= active & ~short_det;
        end
    end

endmodule
`default_nettype wire

// *** core/iopi_edge.sv ***
`default_nettype none
// ----------------------------------------
// change and rise detector
// ----------------------------------------
module iopi_edge #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic              rise,
    output logic              chg
);

    logic [W-1:0] prev_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= '0;
        else
            prev_q <= din;
    end

    assign rise = |(din & ~prev_q);
    assign chg  = |(din ^ prev_q);

endmodule
`default_nettype wire

// *** core/iopi_top.sv ***
// Decided for this implementation: the APB slave port and the address map.
`include "iopi_cfg.svh"
`default_nettype none
module iopi_top #(
    parameter int N_IN_CONN  = 8,
    parameter int N_OUT_CONN = 4
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire iopi_pkg::iopi_apb_req_t  apb_req,
    output var  iopi_pkg::iopi_apb_rsp_t  apb_rsp,
    input  wire logic [N_IN_CONN-1:0]     sensor_input_signal_pin4,
    input  wire logic [N_IN_CONN-1:0]     sensor_input_signal_pin2,
    input  wire logic [N_IN_CONN-1:0]     in_conn_short,
    output logic [2*N_IN_CONN-1:0]        in_process_image,
    output logic [2*N_IN_CONN-1:0]        in_led_green,
    output logic [2*N_IN_CONN-1:0]        in_led_red,
    input  wire logic [2*N_OUT_CONN-1:0]  out_byte_data,
    input  wire logic                     out_byte_valid,
    input  wire logic [2*N_OUT_CONN-1:0]  out_ch_short,
    output logic [N_OUT_CONN-1:0]         out_pin4,
    output logic [N_OUT_CONN-1:0]         out_pin2,
    output logic [2*N_OUT_CONN-1:0]       out_led_green,
    output logic [2*N_OUT_CONN-1:0]       out_led_red,
    output logic                          irq
);

    localparam int N_IN  = 2 * N_IN_CONN;
    localparam int N_OUT = 2 * N_OUT_CONN;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [N_IN-1:0]             in_image_d;
    logic [N_IN-1:0]             in_image_q;
    logic [N_IN-1:0]             in_short_ch;
    logic [N_OUT-1:0]            out_image_q;
    logic [N_OUT-1:0]            out_drv_d;
    logic [N_OUT_CONN-1:0]       pin4_q;
    logic [N_OUT_CONN-1:0]       pin2_q;
    logic [`IOPI_CTRL_W-1:0]     ctrl_q;
    logic [`IOPI_IRQ_W-1:0]      irq_stat_q;
    logic [`IOPI_IRQ_W-1:0]      irq_en_q;
    logic [`IOPI_IRQ_W-1:0]      irq_ev;
    logic [`IOPI_IRQ_W-1:0]      irq_clr;
    logic                        irq_q;
    logic                        in_chg;
    logic                        in_short_rise;
    logic                        out_short_rise;
    logic                        setup;
    logic                        wr_acc;
    logic                        hit;
    logic [31:0]                 rd_data;
    iopi_pkg::iopi_apb_rsp_t     rsp_q;

    // ----------------------------------------
    // input image packing
    // ----------------------------------------
    for (genvar k = 0; k < N_IN_CONN; k++)
    begin : g_in
        assign in_image_d[2*k]     = sensor_input_signal_pin4[k];
        assign in_image_d[2*k+1]   = sensor_input_signal_pin2[k];
        // one short flag per connector lights both of its channels
        assign in_short_ch[2*k]    = in_conn_short[k];
        assign in_short_ch[2*k+1]  = in_conn_short[k];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            in_image_q <= '0;
        else
            in_image_q <= in_image_d;
    end

    assign in_process_image = in_image_q;

    // ----------------------------------------
    // output image and pin drive
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            out_image_q <= '0;
        else if (out_byte_valid)
            out_image_q <= out_byte_data;
    end

    // cutoff drops a shorted channel without touching the stored byte,
    // so it comes back by itself once the short clears
    always_comb
    begin
        out_drv_d = out_image_q & {N_OUT{ctrl_q[`IOPI_CTRL_OUT_EN]}};
        if (ctrl_q[`IOPI_CTRL_CUTOFF])
            out_drv_d = out_drv_d & ~out_ch_short;
    end

    for (genvar k = 0; k < N_OUT_CONN; k++)
    begin : g_out
        always_ff @(posedge clk_sys or negedge rst_n)
        begin
            if (!rst_n)
            begin
                pin4_q[k] <= 1'b0;
                pin2_q[k] <= 1'b0;
            end
            else
            begin
                pin4_q[k] <= out_drv_d[2*k];
                pin2_q[k] <= out_drv_d[2*k+1];
            end
        end
    end

    assign out_pin4 = pin4_q;
    assign out_pin2 = pin2_q;

    // ----------------------------------------
    // indicators
    // ----------------------------------------
    iopi_led #(
        .N (N_IN)
    ) u_in_led (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .active    (in_image_d),
        .short_det (in_short_ch),
        .green_q   (in_led_green),
        .red_q     (in_led_red)
    );

    iopi_led #(
        .N (N_OUT)
    ) u_out_led (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .active    (out_drv_d),
        .short_det (out_ch_short),
        .green_q   (out_led_green),
        .red_q     (out_led_red)
    );

    // ----------------------------------------
    // events
    // ----------------------------------------
    iopi_edge #(
        .W (N_IN)
    ) u_in_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (in_image_d),
        .rise    (),
        .chg     (in_chg)
    );

    iopi_edge #(
        .W (N_IN_CONN)
    ) u_in_short_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (in_conn_short),
        .rise    (in_short_rise),
        .chg     ()
    );

    iopi_edge #(
        .W (N_OUT)
    ) u_out_short_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (out_ch_short),
        .rise    (out_short_rise),
        .chg     ()
    );

    always_comb
    begin
        irq_ev = '0;
        irq_ev[`IOPI_EV_IN_CHG]    = in_chg;
        irq_ev[`IOPI_EV_IN_SHORT]  = in_short_rise;
        irq_ev[`IOPI_EV_OUT_SHORT] = out_short_rise;
        irq_ev[`IOPI_EV_OUT_BYTE]  = out_byte_valid;
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign setup  = apb_req.psel & ~apb_req.penable;
    assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & rsp_q.pready;

    always_comb
    begin
        hit     = 1'b1;
        rd_data = '0;
        case (apb_req.paddr)
            `IOPI_OFF_IN_IMAGE:  rd_data[N_IN-1:0] = in_image_q;
            `IOPI_OFF_OUT_IMAGE: rd_data[N_OUT-1:0] = out_image_q;
            `IOPI_OFF_SHORTS:
            begin
                rd_data[N_IN_CONN-1:0] = in_conn_short;
                rd_data[`IOPI_SHORTS_OUT_LSB +: N_OUT] = out_ch_short;
            end
            `IOPI_OFF_IRQ_STAT:  rd_data[`IOPI_IRQ_W-1:0] = irq_stat_q;
            `IOPI_OFF_IRQ_CLR:   rd_data = '0;
            `IOPI_OFF_IRQ_EN:    rd_data[`IOPI_IRQ_W-1:0] = irq_en_q;
            `IOPI_OFF_CTRL:      rd_data[`IOPI_CTRL_W-1:0] = ctrl_q;
            default:             hit = 1'b0;
        endcase
    end

    // zero wait states: ready rises in the first access cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rsp_q <= '0;
        else
        begin
            rsp_q.pready  <= setup;
            rsp_q.pslverr <= setup & ~hit;
            rsp_q.prdata  <= (setup & ~apb_req.pwrite) ? rd_data : '0;
        end
    end

    assign apb_rsp = rsp_q;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `IOPI_CTRL_RST;
        else if (wr_acc && apb_req.paddr == `IOPI_OFF_CTRL)
            ctrl_q <= apb_req.pwdata[`IOPI_CTRL_W-1:0];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_en_q <= `IOPI_IRQ_RST;
        else if (wr_acc && apb_req.paddr == `IOPI_OFF_IRQ_EN)
            irq_en_q <= apb_req.pwdata[`IOPI_IRQ_W-1:0];
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    assign irq_clr = (wr_acc && apb_req.paddr == `IOPI_OFF_IRQ_CLR)
                   ? apb_req.pwdata[`IOPI_IRQ_W-1:0] : '0;

    // a fresh event outranks a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_stat_q <= `IOPI_IRQ_RST;
        else
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irq_q <= 1'b0;
        else
            irq_q <= |(irq_stat_q & irq_en_q);
    end

    assign irq = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    in_image_read_a: assert property (
        setup && !apb_req.pwrite && apb_req.paddr == `IOPI_OFF_IN_IMAGE
        |=> rsp_q.pready && rsp_q.prdata == {16'h0000, $past(in_image_q)})
        else $error("input image read wrong");

    even_bit_map_a: assert property (
        in_image_q[0] == $past(sensor_input_signal_pin4[0])
        && in_image_q[14] == $past(sensor_input_signal_pin4[7]))
        else $error("pin 4 channel not on even bit");

    odd_bit_map_a: assert property (
        in_image_q[1] == $past(sensor_input_signal_pin2[0])
        && in_image_q[15] == $past(sensor_input_signal_pin2[7]))
        else $error("pin 2 channel not on odd bit");

    conn_pair_a: assert property (
        $rose(sensor_input_signal_pin2[3]) && !sensor_input_signal_pin4[3]
        |=> in_image_q[7:6] == 2'h2)
        else $error("connector channel pair misplaced");

    in_led_green_a: assert property (
        sensor_input_signal_pin4[2] && !in_conn_short[2]
        |=> in_led_green[4] && !in_led_red[4])
        else $error("active input not green");

    in_led_red_a: assert property (
        in_conn_short[5] |=> in_led_red[10] && in_led_red[11])
        else $error("connector short not red on both channels");

    out_byte_take_a: assert property (
        out_byte_valid |=> out_image_q == $past(out_byte_data))
        else $error("output byte not taken");

    out_pin_map_a: assert property (
        ctrl_q == 2'h1 && out_image_q[3:2] == 2'h1
        |=> out_pin4[1] && !out_pin2[1])
        else $error("output connector pins swapped");

    out_led_state_a: assert property (
        out_ch_short[6] |=> out_led_red[6] ##1 !$past(out_ch_short[6])
        || out_led_red[6])
        else $error("output short not shown red");

    out_bit_drive_a: assert property (
        !ctrl_q[`IOPI_CTRL_CUTOFF] && ctrl_q[`IOPI_CTRL_OUT_EN]
        |=> out_pin2[3] == $past(out_image_q[7]))
        else $error("output bit 7 not on pin 2 of last connector");

    red_wins_a: assert property (
        out_ch_short[0] && out_drv_d[0]
        |=> out_led_red[0] && !out_led_green[0])
        else $error("green shown over short");

    irq_sticky_a: assert property (
        irq_ev[`IOPI_EV_OUT_BYTE] && irq_en_q[`IOPI_EV_OUT_BYTE]
        && $stable(irq_en_q) |=> ##1 irq)
        else $error("enabled event raised no interrupt");

    unmapped_err_a: assert property (
        setup && !hit |=> rsp_q.pready && rsp_q.pslverr)
        else $error("unmapped access answered without error");

    // a clear landing with the event must not swallow it
    set_wins_a: assert property (
        irq_ev[`IOPI_EV_OUT_BYTE] |=> irq_stat_q[`IOPI_EV_OUT_BYTE])
        else $error("output byte event lost from status");

endmodule
`default_nettype wire

// *** dv/iopi_su_model.sv ***
`default_nettype none
// ----------------------------------------
// interface unit model: hands over the output byte
// ----------------------------------------
module iopi_su_model (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       send,
    input  wire logic [7:0] byte_in,
    output logic      [7:0] out_byte_data,
    output logic            out_byte_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    // data is only meaningful with the strobe; invert it otherwise
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_byte_valid <= 1'b0;
            out_byte_data  <= 8'h00;
        end
        else if (send)
        begin
            out_byte_valid <= 1'b1;
            out_byte_data  <= byte_in;
        end
        else
        begin
            out_byte_valid <= 1'b0;
            out_byte_data  <= ~out_byte_data;
        end
    end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`include "iopi_cfg.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    clk_sys = 1'b0;
    logic                    rst_n   = 1'b0;
    iopi_pkg::iopi_apb_req_t req     = '0;
    iopi_pkg::iopi_apb_rsp_t rsp;
    logic [7:0]  p4 = 8'h00, p2 = 8'h00, ish = 8'h00, osh = 8'h00;
    logic [7:0]  sbyte = 8'h00;
    logic        send  = 1'b0;
    logic [7:0]  obd;
    logic        obv;
    logic [15:0] img, grn, red;
    logic [7:0]  op_led_g, op_led_r;
    logic [3:0]  o4, o2;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  act;
    logic [1:0]  ctl;
    int          fail_count  = 0;
    int          checks_done = 0;

    always #10 clk_sys = ~clk_sys;

    iopi_su_model u_su (.clk_sys(clk_sys), .rst_n(rst_n), .send(send),
        .byte_in(sbyte), .out_byte_data(obd), .out_byte_valid(obv));

    iopi_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(req),
        .apb_rsp(rsp), .sensor_input_signal_pin4(p4),
        .sensor_input_signal_pin2(p2), .in_conn_short(ish),
        .in_process_image(img), .in_led_green(grn), .in_led_red(red),
        .out_byte_data(obd), .out_byte_valid(obv), .out_ch_short(osh),
        .out_pin4(o4), .out_pin2(o2), .out_led_green(op_led_g),
        .out_led_red(op_led_r), .irq(irq));

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    function automatic logic [15:0] weave(input logic [7:0] a,
                                          input logic [7:0] b);
        for (int k = 0; k < 8; k++)
        begin
            weave[2*k]   = a[k];
            weave[2*k+1] = b[k];
        end
    endfunction

    function automatic logic [3:0] pick(input logic [7:0] b, input int o);
        for (int k = 0; k < 4; k++)
            pick[k] = b[2*k+o];
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one transfer; waits for pready, never for a fixed count
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= wd;
        @(posedge clk_sys);
        req.penable <= 1'b1;
        // no timeout of its own: pready ends this wait, or else the watchdog
        do
            @(posedge clk_sys);
        while (rsp.pready !== 1'b1);
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic push(input logic [7:0] b);
        sbyte <= b;
        send  <= 1'b1;
        @(posedge clk_sys);
        send  <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(11));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, `IOPI_OFF_CTRL, 32'h0);
        chk("ctrl_rst", rd, 32'h1);
        apb(1'b0, `IOPI_OFF_IRQ_EN, 32'h0);
        chk("en_rst", rd, 32'h0);
        $display("reset test done");
        // ----------------------------------------
        // input image and indicators
        // ----------------------------------------
        for (int i = 0; i < 24; i++)
        begin
            p4  <= (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            p2  <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            ish <= (i == 1) ? 8'hFF : (i % 3 == 0) ? 8'($urandom) : 8'h00;
            repeat (2) @(posedge clk_sys);
            chk("image", img, weave(p4, p2));
            chk("in_red", red, weave(ish, ish));
            chk("in_green", grn, weave(p4, p2) & ~weave(ish, ish));
            apb(1'b0, `IOPI_OFF_IN_IMAGE, 32'h0);
            chk("image_reg", rd, {16'h0, weave(p4, p2)});
        end
        apb(1'b1, `IOPI_OFF_IN_IMAGE, 32'hFFFF_FFFF);
        apb(1'b0, `IOPI_OFF_IN_IMAGE, 32'h0);
        chk("image_ro", rd, {16'h0, weave(p4, p2)});
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        $display("input test done");
        // ----------------------------------------
        // output byte: enabled, cutoff, disabled
        // ----------------------------------------
        for (int m = 0; m < 3; m++)
        begin
            ctl = (m == 0) ? 2'h1 : (m == 1) ? 2'h3 : 2'h0;
            apb(1'b1, `IOPI_OFF_CTRL, {30'h0, ctl});
            for (int i = 0; i < 8; i++)
            begin
                osh <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
                push((i == 0) ? 8'hFF : (i == 1) ? 8'hA5 : 8'($urandom));
                act = (ctl[0] ? sbyte : 8'h00) & ~(ctl[1] ? osh : 8'h00);
                chk("pin4", o4, pick(act, 0));
                chk("pin2", o2, pick(act, 1));
                chk("out_red", op_led_r, osh);
                chk("out_green", op_led_g, act & ~osh);
            end
        end
        $display("output test done");
        // ----------------------------------------
        // interrupt: raise, mask, clear
        // ----------------------------------------
        apb(1'b1, `IOPI_OFF_IRQ_CLR, 32'hF);
        apb(1'b0, `IOPI_OFF_IRQ_STAT, 32'h0);
        chk("stat_clr", rd, 32'h0);
        apb(1'b1, `IOPI_OFF_IRQ_EN, 32'h9);
        chk("irq_idle", irq, 1'b0);
        p4 <= ~p4;
        repeat (4) @(posedge clk_sys);
        chk("irq_in", irq, 1'b1);
        apb(1'b1, `IOPI_OFF_IRQ_EN, 32'h8);
        repeat (2) @(posedge clk_sys);
        chk("irq_mask", irq, 1'b0);
        push(8'h3C);
        repeat (2) @(posedge clk_sys);
        chk("irq_byte", irq, 1'b1);
        apb(1'b0, `IOPI_OFF_IRQ_STAT, 32'h0);
        chk("stat", rd & 32'h9, 32'h9);
        apb(1'b1, `IOPI_OFF_IRQ_CLR, 32'hF);
        repeat (2) @(posedge clk_sys);
        chk("irq_clr", irq, 1'b0);
        $display("interrupt test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
